// [pkg/sdc_defs.vh]
`ifndef SDC_DEFS_VH
`define SDC_DEFS_VH
// ----------------------------------------
// Address decode
// ----------------------------------------
`define SDC_SPACE_HI 31
`define SDC_SPACE_LO 26
`define SDC_SPACE_CODE 6'h01
// ----------------------------------------
// Command word {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDC_CMD_NOP 4'h7
`define SDC_CMD_ACT 4'h3
`define SDC_CMD_READ 4'h5
`define SDC_CMD_WRITE 4'h4
`define SDC_CMD_PRE 4'h2
`define SDC_CMD_REF 4'h1
`define SDC_CMD_MRS 4'h0
// ----------------------------------------
// Request op codes
// ----------------------------------------
`define SDC_OP_READ 3'h0
`define SDC_OP_WRITE 3'h1
`define SDC_OP_REFRESH 3'h2
`define SDC_OP_PRECHARGE 3'h3
`define SDC_OP_MODE 3'h4
`define SDC_OP_SELF_REFRESH 3'h5
`define SDC_OP_SUSPEND 3'h6
`define SDC_OP_WAKE 3'h7
// ----------------------------------------
// Request word layout
// ----------------------------------------
`define SDC_REQ_W 37
`define SDC_REQ_OP_HI 36
`define SDC_REQ_OP_LO 34
`define SDC_REQ_SW 33
`define SDC_REQ_ADDR_HI 31
`define SDC_REQ_ADDR_LO 0
// Bit 32 of the request flags a single-word access
`define SDC_REQ_SINGLE 32
// ----------------------------------------
// Address split
// ----------------------------------------
`define SDC_ROW_HI 24
`define SDC_ROW_LO 11
`define SDC_COL_HI 10
`define SDC_COL_LO 1
`define SDC_A10_ROW 21
`define SDC_WORD_ODD 0
`define SDC_FIFO_DEPTH 4
`define SDC_FIFO_AW 2
`endif

// [verilog/sdc_fifo.v]
`timescale 1ns/10ps
module sdc_fifo #(
  parameter WIDTH = 37,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  // ----------------------------------------
  // Flags
  // ----------------------------------------
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem[rd_ptr];
  always @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end
endmodule // sdc_fifo

// [verilog/sdc_ctrl.v]
`timescale 1ns/10ps
`include "sdc_defs.vh"
// Operation
// - Space select when address top bits 000001
// - Only bus master drives space select
// - RAS low with row address presented
// - CAS low with column address presented
// - Other commands encoded per SDRAM table
// - Write enable low write, high read
// - Masks valid at CAS, inactive reads
// - Odd word on 64-bit: low mask
// - Even single word or 32-bit: high mask
// - Separate address bit 10 line
// - Clock enable enters/leaves self-refresh, suspend
// - Self-refresh, then float in the same cycle as host grant
module sdc_ctrl
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_req_valid,
  output wire o_req_ready,
  input wire [2:0] i_req_op,
  input wire [31:0] i_req_addr,
  input wire i_req_single,
  input wire i_bus_width32,
  input wire i_bus_master,
  input wire i_host_bus_request,
  output reg o_host_bus_grant,
  output reg o_busy,
  output reg o_sdram_space_select_n,
  output reg o_sdram_space_select_oe,
  output reg o_ras_n,
  output reg o_cas_n,
  output reg o_sdram_write_enable_n,
  output reg o_ctrl_oe,
  output reg [13:0] o_addr,
  output reg o_addr_oe,
  output reg o_low_word_mask,
  output reg o_high_word_mask,
  output reg o_sdram_addr_bit10,
  output reg o_sdram_clock_enable
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ROW = 3'h1;
  localparam ST_COL = 3'h2;
  localparam ST_CMD = 3'h3;
  localparam ST_HOST = 3'h4;
  localparam ST_HREL = 3'h5;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`SDC_REQ_W-1:0] cur;
  reg in_self_refresh;
  reg in_suspend;
  wire fifo_valid;
  wire fifo_pop;
  wire [`SDC_REQ_W-1:0] fifo_data;
  wire [`SDC_REQ_W-1:0] req_word;
  wire [2:0] op;
  wire [31:0] addr;
  reg next_low_mask;
  reg next_high_mask;

  // Decode used only for the held request, in the row and column cycles
  function in_space;
    input [31:0] a;
    begin
      in_space = (a[`SDC_SPACE_HI:`SDC_SPACE_LO] == `SDC_SPACE_CODE);
    end
  endfunction

  // Reads and writes take the row and column path
  function is_access;
    input [2:0] o;
    begin
      is_access = (o == `SDC_OP_READ) || (o == `SDC_OP_WRITE);
    end
  endfunction

  assign req_word = {i_req_op, i_bus_width32, i_req_single, i_req_addr};

  // ----------------------------------------
  // Request queue
  // ----------------------------------------
  sdc_fifo #(
    .WIDTH(`SDC_REQ_W),
    .DEPTH(`SDC_FIFO_DEPTH),
    .AW(`SDC_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_in_valid(i_req_valid),
    .o_in_ready(o_req_ready),
    .i_in_data(req_word),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  // Host request takes precedence so the bus is not starved by traffic
  assign fifo_pop = (state == ST_IDLE) & fifo_valid & ~i_host_bus_request
    & i_bus_master;
  assign op = cur[`SDC_REQ_OP_HI:`SDC_REQ_OP_LO];
  assign addr = cur[`SDC_REQ_ADDR_HI:`SDC_REQ_ADDR_LO];
  // Pins are driven only by the bus master, and never while granted
  wire drive_ok;
  assign drive_ok = i_bus_master & ~o_host_bus_grant;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (i_host_bus_request & i_bus_master)
          next_state = ST_HOST;
        else if (fifo_pop)
        begin
          if (is_access(fifo_data[`SDC_REQ_OP_HI:`SDC_REQ_OP_LO]))
            next_state = ST_ROW;
          else
            next_state = ST_CMD;
        end
      end
      ST_ROW: next_state = ST_COL;
      ST_COL: next_state = ST_IDLE;
      ST_CMD: next_state = ST_IDLE;
      ST_HOST: next_state = ST_HREL;
      ST_HREL:
      begin
        if (!i_host_bus_request)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Write masks
  // ----------------------------------------
  // Worked out from the held request, so they settle a cycle early
  always @*
  begin
    next_low_mask = 1'b0;
    next_high_mask = 1'b0;
    if (op == `SDC_OP_WRITE)
    begin
      next_low_mask = ~cur[`SDC_REQ_SW] & addr[`SDC_WORD_ODD];
      next_high_mask = cur[`SDC_REQ_SW] |
        (cur[`SDC_REQ_SINGLE] & ~addr[`SDC_WORD_ODD]);
    end
  end

  // ----------------------------------------
  // Request hold
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= ST_IDLE;
      cur <= {`SDC_REQ_W{1'b0}};
      o_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_busy <= (next_state != ST_IDLE);
      // The popped request stays put until the next pop
      if (fifo_pop)
        cur <= fifo_data;
    end
  end

  // ----------------------------------------
  // Sequencer and pins
  // ----------------------------------------
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      in_self_refresh <= 1'b0;
      in_suspend <= 1'b0;
      o_host_bus_grant <= 1'b0;
      o_sdram_space_select_n <= 1'b1;
      o_sdram_space_select_oe <= 1'b0;
      {o_sdram_space_select_n, o_ras_n, o_cas_n, o_sdram_write_enable_n}
        <= `SDC_CMD_NOP;
      o_ctrl_oe <= 1'b0;
      o_addr <= 14'h0000;
      o_addr_oe <= 1'b0;
      o_low_word_mask <= 1'b0;
      o_high_word_mask <= 1'b0;
      o_sdram_addr_bit10 <= 1'b0;
      o_sdram_clock_enable <= 1'b1;
    end
    else
    begin
      // Default: NOP with select low, address floated, masks idle; master keeps select and control driven
      {o_sdram_space_select_n, o_ras_n, o_cas_n, o_sdram_write_enable_n}
        <= `SDC_CMD_NOP;
      o_low_word_mask <= 1'b0;
      o_high_word_mask <= 1'b0;
      o_sdram_space_select_oe <= drive_ok;
      o_ctrl_oe <= drive_ok;
      o_addr_oe <= 1'b0;
      case (state)
        ST_ROW:
        begin
          o_addr <= addr[`SDC_ROW_HI:`SDC_ROW_LO];
          o_addr_oe <= 1'b1;
          o_sdram_addr_bit10 <= addr[`SDC_A10_ROW];
          o_sdram_space_select_n <= ~in_space(addr);
          o_ras_n <= 1'b0;
          o_cas_n <= 1'b1;
          o_sdram_write_enable_n <= 1'b1;
        end
        ST_COL:
        begin
          o_addr <= {4'h0, addr[`SDC_COL_HI:`SDC_COL_LO]};
          o_addr_oe <= 1'b1;
          o_sdram_addr_bit10 <= 1'b0;
          o_sdram_space_select_n <= ~in_space(addr);
          o_ras_n <= 1'b1;
          o_cas_n <= 1'b0;
          o_sdram_write_enable_n <= (op != `SDC_OP_WRITE);
          // Masks only in the column cycle; zero for reads
          o_low_word_mask <= next_low_mask;
          o_high_word_mask <= next_high_mask;
        end
        ST_CMD:
        begin
          o_sdram_addr_bit10 <= 1'b1;
          o_sdram_space_select_n <= 1'b0;
          case (op)
            `SDC_OP_REFRESH:
              {o_sdram_space_select_n, o_ras_n, o_cas_n,
               o_sdram_write_enable_n} <= `SDC_CMD_REF;
            `SDC_OP_PRECHARGE:
              {o_sdram_space_select_n, o_ras_n, o_cas_n,
               o_sdram_write_enable_n} <= `SDC_CMD_PRE;
            `SDC_OP_MODE:
            begin
              {o_sdram_space_select_n, o_ras_n, o_cas_n,
               o_sdram_write_enable_n} <= `SDC_CMD_MRS;
              o_addr <= addr[`SDC_ROW_HI:`SDC_ROW_LO];
              o_addr_oe <= 1'b1;
            end
            `SDC_OP_SELF_REFRESH:
            begin
              {o_sdram_space_select_n, o_ras_n, o_cas_n,
               o_sdram_write_enable_n} <= `SDC_CMD_REF;
              o_sdram_clock_enable <= 1'b0;
              in_self_refresh <= 1'b1;
            end
            `SDC_OP_SUSPEND:
            begin
              o_sdram_clock_enable <= 1'b0;
              in_suspend <= 1'b1;
            end
            `SDC_OP_WAKE:
            begin
              // Waking a memory that is already awake changes nothing
              if (in_self_refresh | in_suspend)
              begin
                o_sdram_clock_enable <= 1'b1;
                in_self_refresh <= 1'b0;
                in_suspend <= 1'b0;
              end
            end
            default:
              {o_sdram_space_select_n, o_ras_n, o_cas_n,
               o_sdram_write_enable_n} <= `SDC_CMD_NOP;
          endcase
        end
        ST_HOST:
        begin
          // Self-refresh entry precedes the grant and the float; a
          // second entry command while already asleep is not issued
          o_sdram_addr_bit10 <= 1'b1;
          if (!in_self_refresh)
          begin
            {o_sdram_space_select_n, o_ras_n, o_cas_n,
             o_sdram_write_enable_n} <= `SDC_CMD_REF;
          end
          o_sdram_clock_enable <= 1'b0;
          in_self_refresh <= 1'b1;
        end
        ST_HREL:
        begin
          o_host_bus_grant <= i_host_bus_request;
          o_sdram_space_select_oe <= 1'b0;
          o_ctrl_oe <= 1'b0;
          if (!i_host_bus_request)
            o_host_bus_grant <= 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end
endmodule // sdc_ctrl

// [sim/sdc_ctrl_properties.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Command pin properties
// ----------------------------------------
module sdc_ctrl_properties
(
  input wire i_clk,
  input wire i_rstn,
  input wire i_bus_master,
  input wire i_host_bus_request,
  input wire o_host_bus_grant,
  input wire o_sdram_space_select_n,
  input wire o_sdram_space_select_oe,
  input wire o_ras_n,
  input wire o_cas_n,
  input wire o_sdram_write_enable_n,
  input wire o_ctrl_oe,
  input wire o_addr_oe,
  input wire o_low_word_mask,
  input wire o_high_word_mask,
  input wire o_sdram_clock_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_act;
    !o_ras_n && o_cas_n && o_sdram_write_enable_n && o_ctrl_oe;
  endsequence
  sequence s_col;
    o_ras_n && !o_cas_n;
  endsequence
  sequence s_nop;
    o_ras_n && o_cas_n && o_sdram_write_enable_n;
  endsequence
  chk_row_then_col: assert property (s_act |=> s_col ##1 s_nop)
    else $error("column cycle did not follow row cycle");
  chk_row_addr_drive: assert property (s_act |-> o_addr_oe)
    else $error("row address not driven");
  chk_col_addr_drive: assert property (s_col |-> o_addr_oe)
    else $error("column address not driven");
  chk_read_masks_low: assert property
    (s_col and o_sdram_write_enable_n |-> !o_low_word_mask
      && !o_high_word_mask)
    else $error("mask active on read");
  chk_slave_float: assert property
    (!i_bus_master |=> !o_sdram_space_select_oe)
    else $error("select driven while not master");
  chk_other_select: assert property
    (!o_ras_n && !o_cas_n && o_ctrl_oe |-> !o_sdram_space_select_n)
    else $error("select not asserted for command");
  chk_grant_float: assert property (o_host_bus_grant |-> !o_ctrl_oe
      && !o_addr_oe && !o_sdram_clock_enable)
    else $error("pins driven or memory awake under grant");
  chk_grant_hold: assert property
    (o_host_bus_grant && i_host_bus_request |=> o_host_bus_grant)
    else $error("grant dropped while host still asks");
endmodule // sdc_ctrl_properties
bind sdc_ctrl sdc_ctrl_properties sdc_ctrl_properties_i (.*);

// [sim/sdc_sdram_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Memory side: logs each driven command it sees except NOP
// ----------------------------------------
module sdc_sdram_model
(
  input wire i_clk,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire i_oe,
  input wire [13:0] i_addr,
  input wire i_hmask,
  input wire i_lmask,
  input wire i_a10,
  input wire i_cke,
  output reg o_seen,
  output reg [21:0] o_word,
  output reg [1:0] o_dq_float
);
  wire [2:0] cmd = {i_ras_n, i_cas_n, i_we_n};
  wire rw = cmd == 3'h3 || cmd[2:1] == 2'h2;
  // Only ten column bits reach the array, so upper bits are ignored
  always @(posedge i_clk)
  begin
    o_seen <= i_oe && cmd != 3'h7;
    o_word <= {i_cke, i_cs_n, cmd, i_a10,
      rw ? (i_cas_n ? i_addr : {4'h0, i_addr[9:0]}) : 14'h0,
      i_cas_n ? 2'h0 : {i_hmask, i_lmask}};
    o_dq_float <= {i_hmask, i_lmask};
  end
endmodule // sdc_sdram_model

// [sim/sdc_ctrl_tb.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Bench
// ----------------------------------------
module sdc_ctrl_tb;
  logic i_clk = 0, i_rstn = 0, i_req_valid = 0, i_req_single = 0;
  logic i_bus_width32 = 0, i_bus_master = 1, i_host_bus_request = 0;
  logic [2:0] i_req_op = 0;
  logic [31:0] i_req_addr = 0;
  wire o_req_ready, o_host_bus_grant, o_busy, o_sdram_space_select_n;
  wire o_sdram_space_select_oe, o_ras_n, o_cas_n, o_sdram_write_enable_n;
  wire o_ctrl_oe, o_addr_oe, o_low_word_mask, o_high_word_mask;
  wire o_sdram_addr_bit10, o_sdram_clock_enable, seen;
  wire [13:0] o_addr;
  wire [21:0] word;
  logic [21:0] q[$];
  int mismatches = 0, comparisons = 0, n, k;
  sdc_ctrl sdc_ctrl_i (.*);
  sdc_sdram_model sdc_sdram_model_i (.i_clk(i_clk),
    .i_cs_n(o_sdram_space_select_n), .i_ras_n(o_ras_n),
    .i_cas_n(o_cas_n), .i_we_n(o_sdram_write_enable_n),
    .i_oe(o_ctrl_oe), .i_addr(o_addr), .i_hmask(o_high_word_mask),
    .i_lmask(o_low_word_mask), .i_a10(o_sdram_addr_bit10),
    .i_cke(o_sdram_clock_enable), .o_seen(seen), .o_word(word),
    .o_dq_float());
  initial forever #20 i_clk = ~i_clk;
  task chk(input [21:0] g, input [21:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Expectations are queued at request time, before anything is taken
  task rq(input [2:0] op, input [31:0] ad, input s, input w);
    logic [3:0] cs;
    logic [3:0] c;
    cs = (ad[31:26] == 6'h01) ? 4'h0 : 4'h8;
    c = (op == 2 || op == 5) ? 4'h1 : (op == 3) ? 4'h2 : 4'h0;
    i_req_valid <= 1'b1;
    i_req_op <= op;
    i_req_addr <= ad;
    i_req_single <= s;
    i_bus_width32 <= w;
    if (op < 2)
    begin
      q.push_back({1'b1, cs | 4'h3, ad[21], ad[24:11], 2'h0});
      q.push_back({1'b1, cs | (op[0] ? 4'h4 : 4'h5), 1'b0, 4'h0,
        ad[10:1], op[0] ? {w | (s & ~ad[0]), ~w & ad[0]} : 2'h0});
    end
    else if (op < 6)
      q.push_back({op != 5, c, 1'b1, 14'h0, 2'h0});
    do @(posedge i_clk); while (o_req_ready !== 1'b1);
  endtask
  task drain;
    i_req_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
    k = 0;
    while ((q.size() != 0 || o_busy !== 1'b0) && k < 80)
    begin
      @(posedge i_clk);
      k++;
    end
    chk(k < 80, 1'b1);
    @(posedge i_clk);
  endtask
  always @(posedge i_clk)
    if (seen === 1'b1)
    begin
      if (q.size() == 0)
        chk(1'b0, 1'b1);
      else
        chk(word, q.pop_front());
    end
  initial
  begin
    #(40 * 6000);
    mismatches++;
    give_verdict;
  end
  initial
  begin
    void'($urandom(92));
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (n = 0; n < 16; n++)
      rq(n[0], {6'h01, 25'($urandom), n[3]}, n[1], n[2]);
    rq(3'h0, 32'h10000040, 1'b0, 1'b0);
    for (n = 2; n < 5; n++)
      rq(n, 32'h04000000, 1'b0, 1'b0);
    drain;
    for (n = 5; n < 7; n++)
    begin
      rq(n, 32'h04000000, 1'b0, 1'b0);
      drain;
      chk(o_sdram_clock_enable, 1'b0);
      rq(3'h7, 32'h04000000, 1'b0, 1'b0);
      drain;
      chk(o_sdram_clock_enable, 1'b1);
    end
    i_bus_master <= 1'b0;
    for (n = 0; n < 4; n++)
      rq(3'h1, {6'h01, 26'h0} | $urandom % 26'h2000000, 1'b1, 1'b0);
    i_req_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(o_req_ready, 1'b0);
    chk(o_sdram_space_select_oe, 1'b0);
    i_bus_master <= 1'b1;
    drain;
    i_host_bus_request <= 1'b1;
    q.push_back({1'b0, 4'h1, 1'b1, 14'h0, 2'h0});
    repeat (6) @(posedge i_clk);
    chk(q.size() == 0, 1'b1);
    chk({o_host_bus_grant, o_ctrl_oe}, 2'h2);
    i_host_bus_request <= 1'b0;
    drain;
    chk(o_host_bus_grant, 1'b0);
    rq(3'h7, 32'h04000000, 1'b0, 1'b0);
    drain;
    chk(o_sdram_clock_enable, 1'b1);
    give_verdict;
  end
endmodule // sdc_ctrl_tb
